// ### hw/aacr_pkg.sv
// constants and types for the adaptive audio clock register block
// Functional notes
// - capture master clock count at each frame start
// - high capture register holds count bits 15:8
// - three byte registers form 24-bit synth word
// - second M divider ratio is field plus one
// - first M divider ratio is field plus one
// - input I divider ratio is field plus one
// - unused divider bits read zero, fields reset zero
// - free-running counter clocked by selected master clock
// - dividers run only while divider enable set
// - two-bit code selects each master clock source
package aacr_pkg;
   localparam logic [15:0] ADDR_SYNTH1_DIV_CTRL = 16'hffe2;
   localparam logic [15:0] ADDR_CAPTURE_HIGH = 16'hffe3;
   localparam logic [15:0] ADDR_CAPTURE_LOW = 16'hffe4;
   localparam logic [15:0] ADDR_SYNTH2_DIV_CTRL = 16'hfff6;
   localparam logic [15:0] ADDR_SYNTH2_FREQ_B2 = 16'hfff7;
   localparam logic [15:0] ADDR_SYNTH2_FREQ_B1 = 16'hfff8;
   localparam logic [15:0] ADDR_SYNTH2_FREQ_B0 = 16'hfff9;

   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [15:0] RESET_COUNT = 16'h0000;
   localparam logic [23:0] RESET_FREQ = 24'h000000;
   localparam logic [3:0] RESET_RATIO = 4'h0;
   localparam logic [2:0] RESET_IRATIO = 3'h0;
   localparam logic [2:0] ZERO_PAD3 = 3'h0;
   localparam logic [3:0] ZERO_PAD4 = 4'h0;

   // field positions inside the divider control bytes
   localparam int M_FIELD_HI = 7;
   localparam int M_FIELD_LO = 4;
   localparam int I_FIELD_HI = 2;
   localparam int I_FIELD_LO = 0;

   // master clock source codes; bit 0 set means the divided input clock
   localparam logic [1:0] SRC_SYNTH1 = 2'h0;
   localparam logic [1:0] SRC_SYNTH2 = 2'h2;

   // divider slots in the generate array
   localparam int DIV_SYNTH1 = 0;
   localparam int DIV_SYNTH2 = 1;
   localparam int DIV_INPUT = 2;
   localparam int DIV_COUNT = 3;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [15:0] addr;
      logic [7:0] data;
   } aacr_req_t;

   typedef struct packed {
      logic [1:0] outOneSel;
      logic [1:0] outTwoSel;
      logic counterUsesTwo;
      logic dividerEnable;
   } aacr_ctrl_t;
endpackage : aacr_pkg

// ### hw/aacr_div.sv
// tick divider: passes one of every ratio+1 input ticks
`timescale 1ns/10ps
module aacr_div (
   input wire logic clk,
   input wire logic rst,
   input wire logic enable,
   input wire logic tickIn,
   input wire logic [3:0] ratio,
   output logic tickOut_q
);
   import aacr_pkg::*;

   logic [3:0] cnt_q;

   ////////////////////////////////////////////////////////////////
   always_ff @(posedge clk) begin
      if (rst || !enable) begin
         cnt_q <= RESET_RATIO;
         tickOut_q <= 1'b0;
      end else if (tickIn) begin
         if (cnt_q >= ratio) begin
            cnt_q <= RESET_RATIO;
            tickOut_q <= 1'b1;
         end else begin
            cnt_q <= cnt_q + 4'h1;
            tickOut_q <= 1'b0;
         end
      end else begin
         tickOut_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////
   div_disabled_a: assert property (@(posedge clk) disable iff (rst)
      !enable |=> !tickOut_q) else $error("divider ticked while disabled");

   div_ratio_a: assert property (@(posedge clk) disable iff (rst)
      tickOut_q |-> $past(tickIn) && $past(cnt_q) >= $past(ratio))
      else $error("divider ticked before ratio reached");

   div_bypass_a: assert property (@(posedge clk) disable iff (rst)
      enable && tickIn && ratio == RESET_RATIO && $stable(ratio) && $past(enable)
      |=> tickOut_q) else $error("ratio zero did not pass tick");
endmodule : aacr_div

// ### hw/aacr_regs.sv
// adaptive audio clock registers, dividers, source select and frame capture
`timescale 1ns/10ps
module aacr_regs (
   input wire logic clk,
   input wire logic rst,
   input aacr_pkg::aacr_req_t busReq,
   output logic [7:0] rdData_q,
   input aacr_pkg::aacr_ctrl_t ctrl,
   input wire logic synth1Tick,
   input wire logic synth2Tick,
   input wire logic extClkPin,
   input wire logic frameStart,
   output logic [23:0] synthFreqWord_q,
   output logic [3:0] synth1Ratio_q,
   output logic [3:0] synth2Ratio_q,
   output logic [2:0] inputRatio_q,
   output logic mclkOneTick_q,
   output logic mclkTwoTick_q
);
   import aacr_pkg::*;

   logic [2:0] extSync_q;
   logic extLevel_q;
   logic extTick;
   logic [DIV_COUNT-1:0] divIn;
   logic [DIV_COUNT-1:0] divOut;
   logic [3:0] divRatio [DIV_COUNT];
   logic [15:0] cycleCount_q;
   logic [15:0] capture_q;
   logic oneNext;
   logic twoNext;
   logic countTick;

   ////////////////////////////////////////////////////////////////
   // pin input: three flops, edge counted once stages two and three agree
   always_ff @(posedge clk) begin
      if (rst) begin
         extSync_q <= ZERO_PAD3;
      end else begin
         extSync_q <= {extSync_q[1:0], extClkPin};
      end
   end
   // level moves only when stages two and three agree, so one bad sample is ignored
   always_ff @(posedge clk) begin
      if (rst) begin
         extLevel_q <= 1'b0;
      end else if (extSync_q[1] == extSync_q[2]) begin
         extLevel_q <= extSync_q[2];
      end
   end
   assign extTick = extSync_q[1] && extSync_q[2] && !extLevel_q;

   ////////////////////////////////////////////////////////////////
   // register writes; nothing in hardware alters these fields
   always_ff @(posedge clk) begin
      if (rst) begin
         synthFreqWord_q <= RESET_FREQ;
         synth1Ratio_q <= RESET_RATIO;
         synth2Ratio_q <= RESET_RATIO;
         inputRatio_q <= RESET_IRATIO;
      end else if (busReq.wr) begin
         case (busReq.addr)
            ADDR_SYNTH2_FREQ_B0: synthFreqWord_q[7:0] <= busReq.data;
            ADDR_SYNTH2_FREQ_B1: synthFreqWord_q[15:8] <= busReq.data;
            ADDR_SYNTH2_FREQ_B2: synthFreqWord_q[23:16] <= busReq.data;
            ADDR_SYNTH2_DIV_CTRL: begin
               synth2Ratio_q <= busReq.data[M_FIELD_HI:M_FIELD_LO];
            end
            ADDR_SYNTH1_DIV_CTRL: begin
               synth1Ratio_q <= busReq.data[M_FIELD_HI:M_FIELD_LO];
               inputRatio_q <= busReq.data[I_FIELD_HI:I_FIELD_LO];
            end
            default: ;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////
   // register reads; unmapped addresses return zero
   always_ff @(posedge clk) begin
      if (rst) begin
         rdData_q <= RESET_BYTE;
      end else if (busReq.rd) begin
         case (busReq.addr)
            ADDR_SYNTH2_FREQ_B0: rdData_q <= synthFreqWord_q[7:0];
            ADDR_SYNTH2_FREQ_B1: rdData_q <= synthFreqWord_q[15:8];
            ADDR_SYNTH2_FREQ_B2: rdData_q <= synthFreqWord_q[23:16];
            ADDR_SYNTH2_DIV_CTRL: rdData_q <= {synth2Ratio_q, ZERO_PAD4};
            ADDR_SYNTH1_DIV_CTRL: rdData_q <= {synth1Ratio_q, 1'b0, inputRatio_q};
            ADDR_CAPTURE_HIGH: rdData_q <= capture_q[15:8];
            ADDR_CAPTURE_LOW: rdData_q <= capture_q[7:0];
            default: rdData_q <= RESET_BYTE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////
   // dividers after each synthesizer and on the external input
   assign divIn[DIV_SYNTH1] = synth1Tick;
   assign divIn[DIV_SYNTH2] = synth2Tick;
   assign divIn[DIV_INPUT] = extTick;
   assign divRatio[DIV_SYNTH1] = synth1Ratio_q;
   assign divRatio[DIV_SYNTH2] = synth2Ratio_q;
   assign divRatio[DIV_INPUT] = {1'b0, inputRatio_q};

   genvar g;
   generate
      for (g = 0; g < DIV_COUNT; g++) begin : gDiv
         aacr_div uDiv (
            .clk(clk),
            .rst(rst),
            .enable(ctrl.dividerEnable),
            .tickIn(divIn[g]),
            .ratio(divRatio[g]),
            .tickOut_q(divOut[g])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////
   // source select; x1 wins so both odd codes pick the input clock
   function automatic logic pickSource(input logic [1:0] sel, input logic [2:0] ticks);
      if (sel[0]) begin
         return ticks[DIV_INPUT];
      end else if (sel == SRC_SYNTH2) begin
         return ticks[DIV_SYNTH2];
      end else begin
         return ticks[DIV_SYNTH1];
      end
   endfunction : pickSource

   assign oneNext = pickSource(ctrl.outOneSel, divOut);
   assign twoNext = pickSource(ctrl.outTwoSel, divOut);

   always_ff @(posedge clk) begin
      if (rst) begin
         mclkOneTick_q <= 1'b0;
         mclkTwoTick_q <= 1'b0;
      end else begin
         mclkOneTick_q <= oneNext;
         mclkTwoTick_q <= twoNext;
      end
   end

   ////////////////////////////////////////////////////////////////
   // free-running cycle counter and frame capture
   assign countTick = ctrl.counterUsesTwo ? mclkTwoTick_q : mclkOneTick_q;

   always_ff @(posedge clk) begin
      if (rst) begin
         cycleCount_q <= RESET_COUNT;
      end else if (countTick) begin
         cycleCount_q <= cycleCount_q + 16'h0001;
      end
   end

   // one 16-bit load keeps both bytes from the same frame
   always_ff @(posedge clk) begin
      if (rst) begin
         capture_q <= RESET_COUNT;
      end else if (frameStart) begin
         capture_q <= cycleCount_q;
      end
   end

   ////////////////////////////////////////////////////////////////
   sequence freqWrite2;
      busReq.wr && busReq.addr == ADDR_SYNTH2_FREQ_B2;
   endsequence

   sequence freqRead2;
      busReq.rd && !busReq.wr && busReq.addr == ADDR_SYNTH2_FREQ_B2;
   endsequence

   sequence ctrl1Write;
      busReq.wr && busReq.addr == ADDR_SYNTH1_DIV_CTRL;
   endsequence

   capture_load_a: assert property (@(posedge clk) disable iff (rst)
      frameStart |=> capture_q == $past(cycleCount_q))
      else $error("capture missed frame start");

   capture_hold_a: assert property (@(posedge clk) disable iff (rst)
      !frameStart |=> $stable(capture_q)) else $error("capture changed between frames");

   high_read_a: assert property (@(posedge clk) disable iff (rst)
      busReq.rd && busReq.addr == ADDR_CAPTURE_HIGH |=> rdData_q == $past(capture_q[15:8]))
      else $error("high capture read wrong");

   low_read_a: assert property (@(posedge clk) disable iff (rst)
      busReq.rd && busReq.addr == ADDR_CAPTURE_LOW |=> rdData_q == $past(capture_q[7:0]))
      else $error("low capture read wrong");

   m1_field_a: assert property (@(posedge clk) disable iff (rst)
      ctrl1Write |=> synth1Ratio_q == $past(busReq.data[M_FIELD_HI:M_FIELD_LO]))
      else $error("first M field not stored");

   i_field_a: assert property (@(posedge clk) disable iff (rst)
      ctrl1Write |=> inputRatio_q == $past(busReq.data[I_FIELD_HI:I_FIELD_LO]))
      else $error("I field not stored");

   freq_roundtrip_a: assert property (@(posedge clk) disable iff (rst)
      (freqWrite2 ##1 freqRead2) |=> rdData_q == $past(busReq.data, 2))
      else $error("frequency byte two did not read back");

   ctrl2_reserved_a: assert property (@(posedge clk) disable iff (rst)
      busReq.rd && busReq.addr == ADDR_SYNTH2_DIV_CTRL |=> rdData_q[3:0] == ZERO_PAD4)
      else $error("reserved bits of second divider control not zero");

   ctrl1_reserved_a: assert property (@(posedge clk) disable iff (rst)
      busReq.rd && busReq.addr == ADDR_SYNTH1_DIV_CTRL |=> !rdData_q[3])
      else $error("reserved bit of first divider control not zero");

   counter_step_a: assert property (@(posedge clk) disable iff (rst)
      countTick |=> cycleCount_q == $past(cycleCount_q) + 16'h0001)
      else $error("counter did not step on master clock");

   source_two_a: assert property (@(posedge clk) disable iff (rst)
      ctrl.outTwoSel == SRC_SYNTH2 && divOut[DIV_SYNTH2] |=> mclkTwoTick_q)
      else $error("second output not fed by second synthesizer");

   source_input_a: assert property (@(posedge clk) disable iff (rst)
      ctrl.outOneSel[0] && divOut[DIV_INPUT] |=> mclkOneTick_q)
      else $error("odd code did not pick the input clock");

   disabled_quiet_a: assert property (@(posedge clk) disable iff (rst)
      !ctrl.dividerEnable [*2] |=> !mclkOneTick_q && !mclkTwoTick_q)
      else $error("master clock ticked with dividers disabled");
endmodule : aacr_regs

// ### dv/aacr_codec_model.sv
// clock source and codec side: makes synth ticks and pin clock, counts master clocks
`timescale 1ns/10ps
module aacr_codec_model (
   input wire logic clk,
   input wire logic run,
   input wire logic clrCnt,
   input wire logic mclkOne,
   input wire logic mclkTwo,
   output logic synth1Tick,
   output logic synth2Tick,
   output logic extClk,
   output logic [7:0] nOne,
   output logic [7:0] nTwo
);
   logic [1:0] phase_q;
   // one tick and one pin rising edge every four cycles; all stand still between bursts
   always_ff @(posedge clk) begin
      phase_q <= run ? phase_q + 2'h1 : 2'h0;
      synth1Tick <= run && phase_q == 2'h0;
      synth2Tick <= run && phase_q == 2'h0;
      extClk <= run && phase_q[1];
      nOne <= clrCnt ? 8'h00 : nOne + {7'h00, mclkOne};
      nTwo <= clrCnt ? 8'h00 : nTwo + {7'h00, mclkTwo};
   end
endmodule : aacr_codec_model

// ### dv/aacr_regs_tb.sv
// self-checking bench for the audio clock register block
`timescale 1ns/10ps
module aacr_regs_tb;
   import aacr_pkg::*;
   logic clk, rst, frameStart, run, clrCnt, s1, s2, ext, m1, m2;
   aacr_req_t req;
   aacr_ctrl_t ctl;
   logic [7:0] rdData, nOne, nTwo, hi, lo;
   logic [23:0] word;
   logic [3:0] r1, r2;
   logic [2:0] ri;
   logic [15:0] capA;
   int fails, n_checks;
   logic [15:0] addrs [8] = '{16'hffe2, 16'hffe3, 16'hffe4, 16'hfff6, 16'hfff7,
      16'hfff8, 16'hfff9, 16'hffe0};
   // rows: source code, enable, expected master clocks out of 32 ticks
   logic [1:0] sels [5] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h0};
   logic ens [5] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
   logic [7:0] exps [5] = '{8'h08, 8'h10, 8'h04, 8'h10, 8'h00};
   aacr_regs dut_u (.clk(clk), .rst(rst), .busReq(req), .rdData_q(rdData), .ctrl(ctl),
      .synth1Tick(s1), .synth2Tick(s2), .extClkPin(ext), .frameStart(frameStart),
      .synthFreqWord_q(word), .synth1Ratio_q(r1), .synth2Ratio_q(r2),
      .inputRatio_q(ri), .mclkOneTick_q(m1), .mclkTwoTick_q(m2));
   aacr_codec_model codec_u (.clk(clk), .run(run), .clrCnt(clrCnt), .mclkOne(m1),
      .mclkTwo(m2), .synth1Tick(s1), .synth2Tick(s2), .extClk(ext), .nOne(nOne),
      .nTwo(nTwo));
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fails++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   // extra idle edge keeps a strobe from being assigned twice in one step
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      req <= '{wr: 1'b1, rd: 1'b0, addr: a, data: d};
      @(posedge clk);
      req.wr <= 1'b0;
      @(posedge clk);
   endtask : wr
   task automatic rd(input logic [15:0] a, output logic [7:0] v);
      req <= '{wr: 1'b0, rd: 1'b1, addr: a, data: 8'h00};
      @(posedge clk);
      req.rd <= 1'b0;
      @(posedge clk);
      v = rdData;
   endtask : rd
   // write then read the same address on the very next edge
   task automatic write_read(input logic [15:0] a, input logic [7:0] d, output logic [7:0] v);
      req <= '{wr: 1'b1, rd: 1'b0, addr: a, data: d};
      @(posedge clk);
      req <= '{wr: 1'b0, rd: 1'b1, addr: a, data: d};
      @(posedge clk);
      req.rd <= 1'b0;
      @(posedge clk);
      v = rdData;
   endtask : write_read
   task automatic burst();
      clrCnt <= 1'b1;
      @(posedge clk);
      clrCnt <= 1'b0;
      run <= 1'b1;
      repeat (128) @(posedge clk);
      run <= 1'b0;
      repeat (12) @(posedge clk);
   endtask : burst
   task automatic frame(output logic [15:0] c);
      frameStart <= 1'b1;
      @(posedge clk);
      frameStart <= 1'b0;
      @(posedge clk);
      rd(ADDR_CAPTURE_HIGH, hi);
      rd(ADDR_CAPTURE_LOW, lo);
      c = {hi, lo};
   endtask : frame
   task automatic complete_run();
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : complete_run
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (20000) @(posedge clk);
      fails++;
      complete_run();
   end
   initial begin
      logic [15:0] capB;
      fails = 0;
      n_checks = 0;
      rst = 1'b1;
      frameStart = 1'b0;
      run = 1'b0;
      clrCnt = 1'b0;
      req = '0;
      ctl = '0;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      foreach (addrs[i]) begin
         rd(addrs[i], hi);
         chk(hi, 8'h00);
      end
      wr(ADDR_CAPTURE_HIGH, 8'haa);
      rd(ADDR_CAPTURE_HIGH, hi);
      chk(hi, 8'h00);
      wr(ADDR_SYNTH2_FREQ_B0, 8'h11);
      wr(ADDR_SYNTH2_FREQ_B1, 8'h22);
      write_read(ADDR_SYNTH2_FREQ_B2, 8'h5a, hi);
      chk(hi, 8'h5a);
      wr(ADDR_SYNTH2_FREQ_B2, 8'h33);
      chk(word, 24'h332211);
      rd(ADDR_SYNTH2_FREQ_B1, hi);
      chk(hi, 8'h22);
      wr(ADDR_SYNTH1_DIV_CTRL, 8'hff);
      wr(ADDR_SYNTH2_DIV_CTRL, 8'hff);
      rd(ADDR_SYNTH1_DIV_CTRL, hi);
      chk(hi, 8'hf7);
      rd(ADDR_SYNTH2_DIV_CTRL, hi);
      chk(hi, 8'hf0);
      chk({r1, r2, 1'b0, ri}, 12'hff7);
      // software programs the ratios: M1 = 3, M2 = 7, I = 1
      wr(ADDR_SYNTH1_DIV_CTRL, 8'h31);
      wr(ADDR_SYNTH2_DIV_CTRL, 8'h70);
      foreach (sels[i]) begin
         ctl <= '{outOneSel: sels[i], outTwoSel: sels[i], counterUsesTwo: 1'b0,
            dividerEnable: ens[i]};
         @(posedge clk);
         burst();
         chk(nOne, exps[i]);
         chk(nTwo, exps[i]);
      end
      for (int u = 0; u < 2; u++) begin
         ctl <= '{outOneSel: SRC_SYNTH1, outTwoSel: SRC_SYNTH2, counterUsesTwo: u[0],
            dividerEnable: 1'b1};
         @(posedge clk);
         frame(capA);
         burst();
         frame(capB);
         chk(capB, capA + (u == 1 ? 16'h0004 : 16'h0008));
      end
      chk(word, 24'h332211);
      complete_run();
   end
endmodule : aacr_regs_tb
